// [src/tts_trace_trigger_sequencer.sv]
// trigger sequencer and capture window of the bus-state analyzer
`timescale 1ns/1ps
module tts_trace_trigger_sequencer #(
	parameter int AW = 24,
	parameter int DW = 16,
	parameter int SW = 8,
	parameter int CW = 16
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [tts_pkg::ABW-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// captured bus cycle stream
	input wire logic cyc_valid,
	input wire logic [AW-1:0] cyc_addr,
	input wire logic [DW-1:0] cyc_data,
	input wire logic [SW-1:0] cyc_stat,
	input wire logic store_qual,
	// trace record stream
	output logic rec_valid,
	output logic [AW-1:0] rec_addr,
	output logic [DW-1:0] rec_data,
	output logic [SW-1:0] rec_stat,
	output logic rec_adv_tag,
	output logic rec_trig,
	// trigger and interrupt
	output logic trig_out,
	output logic irq
);
	localparam int NQ = tts_pkg::NQUAL;
	localparam int DSW = DW + SW;

	// configuration
	logic [7:0] ctrl_reg;
	logic [tts_pkg::NEV-1:0] irq_stat_reg;
	logic [tts_pkg::NEV-1:0] irq_mask_reg;
	logic [AW-1:0] qa_val_reg [NQ];
	logic [AW-1:0] qa_msk_reg [NQ];
	logic [DSW-1:0] qd_val_reg [NQ];
	logic [DSW-1:0] qd_msk_reg [NQ];
	logic [CW-1:0] cnt_reg [tts_pkg::NTERM];

	// sequencer state
	tts_pkg::tts_state_type state_reg;
	tts_pkg::tts_state_type state_next;
	logic [2:0] term_reg;
	logic [2:0] term_next;
	logic [CW-1:0] occ_reg;
	logic [CW-1:0] occ_next;
	logic win_open_reg;
	logic win_open_next;

	// register decode
	wire logic [3:0] q_page = addr[7:4];
	wire logic [3:0] q_idx = q_page - tts_pkg::QUAL_PAGE0;
	wire logic [1:0] q_fld = addr[3:2];
	wire logic q_hit = (addr[9:8] == 2'h0) && (q_page >= tts_pkg::QUAL_PAGE0)
		&& (q_idx < 4'(NQ)) && (addr[1:0] == 2'h0);
	wire logic [2:0] c_idx = addr[4:2];
	wire logic c_hit = (addr[9:8] == tts_pkg::CNT_PAGE) && (addr[7:5] == 3'h0)
		&& (c_idx < 3'(tts_pkg::NTERM)) && (addr[1:0] == 2'h0);
	wire logic wr_ctrl = wr && (addr == tts_pkg::OFS_CTRL);
	wire logic wr_stat = wr && (addr == tts_pkg::OFS_IRQ_STAT);
	wire logic wr_mask = wr && (addr == tts_pkg::OFS_IRQ_MASK);
	wire logic wr_qual = wr && q_hit;
	wire logic wr_cnt = wr && c_hit;

	// control fields
	wire logic run = ctrl_reg[tts_pkg::CTRL_RUN];
	wire logic win = ctrl_reg[tts_pkg::CTRL_WIN];
	wire logic rst_en = ctrl_reg[tts_pkg::CTRL_RST_EN];
	wire logic dis_en = ctrl_reg[tts_pkg::CTRL_DIS_EN];
	wire logic [2:0] last_cfg = ctrl_reg[tts_pkg::CTRL_LAST_LSB+:3];
	wire logic [2:0] last_lim = (last_cfg > 3'(tts_pkg::NTERM - 1)) ?
		3'(tts_pkg::NTERM - 1) : last_cfg;
	// a longer chain is clipped rather than refused, so software sees no error
	wire logic [2:0] eff_last = (win && last_lim > 3'(tts_pkg::WIN_NTERM - 1)) ?
		3'(tts_pkg::WIN_NTERM - 1) : last_lim;

	// qualifier comparators
	wire logic [DSW-1:0] cyc_ds = {cyc_stat, cyc_data};
	logic [NQ-1:0] match;
	for (genvar q = 0; q < NQ; q++) begin : g_match
		assign match[q] = (((cyc_addr ^ qa_val_reg[q]) & qa_msk_reg[q]) == '0)
			&& (((cyc_ds ^ qd_val_reg[q]) & qd_msk_reg[q]) == '0);
	end

	// sequencing decisions
	wire logic live = cyc_valid && (state_reg != tts_pkg::ST_IDLE);
	wire logic step = cyc_valid && (state_reg == tts_pkg::ST_SEARCH);
	wire logic en_hit = live && win && match[tts_pkg::Q_ENABLE] && !win_open_reg;
	wire logic dis_hit = live && win && dis_en && match[tts_pkg::Q_DISABLE]
		&& win_open_reg;
	wire logic in_win = win_open_reg || en_hit;
	wire logic rst_hit = step && !win && rst_en && match[tts_pkg::Q_RESTART];
	wire logic is_last = (term_reg == eff_last);
	wire logic term_hit = step && match[term_reg]
		&& (!win || !is_last || in_win);
	wire logic [CW-1:0] cnt_cur = cnt_reg[term_reg];
	wire logic [CW-1:0] need = (win || cnt_cur == '0) ?
		CW'(1) : cnt_cur;
	wire logic [CW:0] occ_inc = {1'b0, occ_reg} + (CW+1)'(1);
	wire logic count_ok = (occ_inc >= {1'b0, need});
	wire logic adv = term_hit && count_ok && !rst_hit;
	wire logic trig = adv && is_last;
	wire logic tag = adv || rst_hit || en_hit || dis_hit;
	// forced storage ignores the store qualifier; the window replaces it
	wire logic store = live && (tag || trig
		|| (win ? in_win : store_qual));
	wire logic [tts_pkg::NEV-1:0] ev = {en_hit || dis_hit, rst_hit, adv, trig};
	wire logic [tts_pkg::NEV-1:0] clr = wr_stat ? wdata[tts_pkg::NEV-1:0] : '0;
	// set wins over a simultaneous write-one-to-clear
	wire logic [tts_pkg::NEV-1:0] irq_stat_next = (irq_stat_reg & ~clr) | ev;

	always_comb begin
		state_next = state_reg;
		term_next = term_reg;
		occ_next = occ_reg;
		win_open_next = win_open_reg;
		case (state_reg)
			tts_pkg::ST_IDLE: begin
				term_next = 3'h0;
				occ_next = '0;
				win_open_next = 1'b0;
				if (run) begin
					state_next = tts_pkg::ST_SEARCH;
				end
			end
			tts_pkg::ST_SEARCH: begin
				if (rst_hit) begin
					term_next = 3'h0;
					occ_next = '0;
				end else if (trig) begin
					state_next = tts_pkg::ST_DONE;
					occ_next = '0;
				end else if (adv) begin
					term_next = term_reg + 3'h1;
					occ_next = '0;
				end else if (term_hit) begin
					occ_next = occ_inc[CW-1:0];
				end
			end
			tts_pkg::ST_DONE: begin
				term_next = term_reg;
			end
			default: begin
				state_next = tts_pkg::ST_IDLE;
			end
		endcase
		if (en_hit) begin
			win_open_next = 1'b1;
		end else if (dis_hit) begin
			win_open_next = 1'b0;
		end
		if (!run) begin
			state_next = tts_pkg::ST_IDLE;
		end
	end

	// read mux
	wire logic [7:0] status_word = {1'b0, run, win_open_reg,
		state_reg == tts_pkg::ST_DONE, 1'b0, term_reg};
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		if (addr == tts_pkg::OFS_CTRL) begin
			rd_val = {24'h00_0000, ctrl_reg};
		end else if (addr == tts_pkg::OFS_STATUS) begin
			rd_val = {24'h00_0000, status_word};
		end else if (addr == tts_pkg::OFS_IRQ_STAT) begin
			rd_val = {28'h000_0000, irq_stat_reg};
		end else if (addr == tts_pkg::OFS_IRQ_MASK) begin
			rd_val = {28'h000_0000, irq_mask_reg};
		end else if (c_hit) begin
			rd_val = 32'(cnt_reg[c_idx]);
		end else if (q_hit) begin
			case (q_fld)
				tts_pkg::F_AVAL: rd_val = 32'(qa_val_reg[q_idx]);
				tts_pkg::F_AMSK: rd_val = 32'(qa_msk_reg[q_idx]);
				tts_pkg::F_DVAL: rd_val = 32'(qd_val_reg[q_idx]);
				default: rd_val = 32'(qd_msk_reg[q_idx]);
			endcase
		end
	end

	// software registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_reg <= tts_pkg::CTRL_RST;
			irq_mask_reg <= tts_pkg::MASK_RST;
			irq_stat_reg <= '0;
			rdata <= 32'h0000_0000;
		end else begin
			if (wr_ctrl) ctrl_reg <= wdata[7:0];
			if (wr_mask) irq_mask_reg <= wdata[tts_pkg::NEV-1:0];
			irq_stat_reg <= irq_stat_next;
			rdata <= rd ? rd_val : 32'h0000_0000;
		end
	end

	// qualifiers reset to all-zero masks, so an unprogrammed term matches any cycle
	always_ff @(posedge mclk) begin
		for (int i = 0; i < NQ; i++) begin
			if (rst) begin
				qa_val_reg[i] <= '0;
				qa_msk_reg[i] <= '0;
				qd_val_reg[i] <= '0;
				qd_msk_reg[i] <= '0;
			end else if (wr_qual && q_idx == 4'(i)) begin
				if (q_fld == tts_pkg::F_AVAL) qa_val_reg[i] <= wdata[AW-1:0];
				if (q_fld == tts_pkg::F_AMSK) qa_msk_reg[i] <= wdata[AW-1:0];
				if (q_fld == tts_pkg::F_DVAL) qd_val_reg[i] <= wdata[DSW-1:0];
				if (q_fld == tts_pkg::F_DMSK) qd_msk_reg[i] <= wdata[DSW-1:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		for (int i = 0; i < tts_pkg::NTERM; i++) begin
			if (rst) begin
				cnt_reg[i] <= tts_pkg::CNT_RST;
			end else if (wr_cnt && c_idx == 3'(i)) begin
				cnt_reg[i] <= wdata[CW-1:0];
			end
		end
	end

	// sequencer and window
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= tts_pkg::ST_IDLE;
			term_reg <= 3'h0;
			occ_reg <= '0;
			win_open_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			term_reg <= term_next;
			occ_reg <= occ_next;
			win_open_reg <= win_open_next;
		end
	end

	// trace record, trigger and interrupt
	always_ff @(posedge mclk) begin
		if (rst) begin
			rec_valid <= 1'b0;
			rec_addr <= '0;
			rec_data <= '0;
			rec_stat <= '0;
			rec_adv_tag <= 1'b0;
			rec_trig <= 1'b0;
			trig_out <= 1'b0;
			irq <= 1'b0;
		end else begin
			rec_valid <= store;
			rec_addr <= cyc_addr;
			rec_data <= cyc_data;
			rec_stat <= cyc_stat;
			rec_adv_tag <= store && tag;
			rec_trig <= store && trig;
			trig_out <= state_next == tts_pkg::ST_DONE;
			irq <= |(irq_stat_next & irq_mask_reg);
		end
	end

	// checks
	localparam int WIN_MAX = tts_pkg::WIN_NTERM;
	sequence s_tagged_rec;
		rec_valid && rec_adv_tag;
	endsequence
	sequence s_first_term;
		term_reg == 3'h0 && state_reg == tts_pkg::ST_SEARCH;
	endsequence

	property p_step_next;
		@(posedge mclk) disable iff (rst)
		adv && !is_last |=> term_reg == $past(term_reg) + 3'h1;
	endproperty
	a_step_next: assert property (p_step_next) else $error("term did not advance");

	property p_trig_last;
		@(posedge mclk) disable iff (rst)
		$rose(trig_out) |-> $past(term_reg) == $past(eff_last) && $past(step);
	endproperty
	a_trig_last: assert property (p_trig_last) else $error("trigger not on last term");

	property p_occ_hold;
		@(posedge mclk) disable iff (rst)
		step && !win && !rst_hit && match[term_reg] && cnt_cur > CW'(1)
			&& occ_reg == '0 |=> $stable(term_reg) && occ_reg == CW'(1);
	endproperty
	a_occ_hold: assert property (p_occ_hold) else $error("counted term advanced early");

	property p_restart;
		@(posedge mclk) disable iff (rst)
		rst_hit ##0 run |=> s_first_term ##1 (term_reg <= 3'h1);
	endproperty
	a_restart: assert property (p_restart) else $error("restart missed");

	property p_forced_store;
		@(posedge mclk) disable iff (rst)
		live && (adv || rst_hit) && !store_qual |=> s_tagged_rec;
	endproperty
	a_forced_store: assert property (p_forced_store) else $error("advance not stored");

	property p_window_open;
		@(posedge mclk) disable iff (rst)
		en_hit && run |=> s_tagged_rec and win_open_reg;
	endproperty
	a_window_open: assert property (p_window_open) else $error("window did not open");

	property p_window_close;
		@(posedge mclk) disable iff (rst)
		dis_hit && run |=> s_tagged_rec and !win_open_reg;
	endproperty
	a_window_close: assert property (p_window_close) else $error("window did not close");

	property p_window_all;
		@(posedge mclk) disable iff (rst)
		live && win && win_open_reg |=> rec_valid;
	endproperty
	a_window_all: assert property (p_window_all) else $error("window state dropped");

	property p_trig_in_win;
		@(posedge mclk) disable iff (rst)
		$rose(trig_out) && $past(win) |-> $past(in_win);
	endproperty
	a_trig_in_win: assert property (p_trig_in_win) else $error("trigger outside window");

	property p_win_terms;
		@(posedge mclk) disable iff (rst)
		win && state_reg == tts_pkg::ST_SEARCH |-> term_reg < 3'(WIN_MAX);
	endproperty
	a_win_terms: assert property (p_win_terms) else $error("too many window terms");

	property p_win_norestart;
		@(posedge mclk) disable iff (rst)
		step && win && run && match[tts_pkg::Q_RESTART] && !adv
			|=> $stable(term_reg);
	endproperty
	a_win_norestart: assert property (p_win_norestart) else $error("restart in window");

	property p_win_single;
		@(posedge mclk) disable iff (rst)
		step && win && run && match[term_reg] && !is_last
			|=> term_reg == $past(term_reg) + 3'h1;
	endproperty
	a_win_single: assert property (p_win_single) else $error("window term needs count");
endmodule // tts_trace_trigger_sequencer

// [src/tts_pkg.sv]
// shared constants for the trace trigger sequencer
package tts_pkg;
	localparam int NTERM = 7;
	localparam int WIN_NTERM = 4;
	localparam int NQUAL = 10;
	localparam int Q_RESTART = 7;
	localparam int Q_ENABLE = 8;
	localparam int Q_DISABLE = 9;
	localparam int NEV = 4;
	localparam int ABW = 10;
	localparam logic [ABW-1:0] OFS_CTRL = 10'h000;
	localparam logic [ABW-1:0] OFS_STATUS = 10'h004;
	localparam logic [ABW-1:0] OFS_IRQ_STAT = 10'h008;
	localparam logic [ABW-1:0] OFS_IRQ_MASK = 10'h00C;
	localparam logic [3:0] QUAL_PAGE0 = 4'h4;
	localparam logic [1:0] CNT_PAGE = 2'h1;
	localparam logic [1:0] F_AVAL = 2'h0;
	localparam logic [1:0] F_AMSK = 2'h1;
	localparam logic [1:0] F_DVAL = 2'h2;
	localparam logic [1:0] F_DMSK = 2'h3;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_WIN = 1;
	localparam int CTRL_RST_EN = 2;
	localparam int CTRL_DIS_EN = 3;
	localparam int CTRL_LAST_LSB = 4;
	localparam int ST_TERM_LSB = 0;
	localparam int ST_DONE_BIT = 4;
	localparam int ST_WIN_BIT = 5;
	localparam int ST_RUN_BIT = 6;
	localparam int EV_TRIG = 0;
	localparam int EV_ADV = 1;
	localparam int EV_RESTART = 2;
	localparam int EV_WIN = 3;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [3:0] MASK_RST = 4'h0;
	localparam logic [15:0] CNT_RST = 16'h0000;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_SEARCH = 3'h2,
		ST_DONE = 3'h4
	} tts_state_type;
endpackage

// [testbench/tts_bus_source.sv]
// bus cycle source standing in for the emulated processor and its state comparators
`timescale 1ns/1ps
module tts_bus_source #(
	parameter int AW = 24,
	parameter int DW = 16,
	parameter int SW = 8
) (
	// clock
	input wire logic mclk,
	// captured bus cycle stream
	output logic cyc_valid,
	output logic [AW-1:0] cyc_addr,
	output logic [DW-1:0] cyc_data,
	output logic [SW-1:0] cyc_stat,
	output logic store_qual
);
	initial begin
		cyc_valid = 1'b0;
		cyc_addr = '0;
		cyc_data = '0;
		cyc_stat = '0;
		store_qual = 1'b0;
	end

	// one whole bus cycle per call; gap idles first to model a slow processor
	task automatic send(input logic [AW-1:0] a, input logic sq, input int gap);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		cyc_valid <= 1'b1;
		cyc_addr <= a;
		cyc_data <= ~a[DW-1:0];
		cyc_stat <= a[SW-1:0];
		store_qual <= sq;
		@(posedge mclk);
		cyc_valid <= 1'b0;
		// fields mean nothing between cycles, so never leave a stale match showing
		cyc_addr <= ~a;
		cyc_data <= a[DW-1:0];
		cyc_stat <= ~a[SW-1:0];
		store_qual <= ~sq;
	endtask
endmodule // tts_bus_source

// [testbench/test_trace_trigger_sequencer.sv]
// self-checking bench for the trace trigger sequencer
`timescale 1ns/1ps
module test_trace_trigger_sequencer;
	logic mclk;
	logic rst;
	logic [tts_pkg::ABW-1:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic cyc_valid;
	logic [23:0] cyc_addr;
	logic [15:0] cyc_data;
	logic [7:0] cyc_stat;
	logic store_qual;
	logic rec_valid;
	logic [23:0] rec_addr;
	logic [15:0] rec_data;
	logic [7:0] rec_stat;
	logic rec_adv_tag;
	logic rec_trig;
	logic trig_out;
	logic irq;
	int failures;
	int checked;
	int cycles;

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	tts_trace_trigger_sequencer u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
		.cyc_data(cyc_data), .cyc_stat(cyc_stat), .store_qual(store_qual),
		.rec_valid(rec_valid), .rec_addr(rec_addr), .rec_data(rec_data), .rec_stat(rec_stat),
		.rec_adv_tag(rec_adv_tag), .rec_trig(rec_trig), .trig_out(trig_out), .irq(irq));

	tts_bus_source u_far (.mclk(mclk), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
		.cyc_data(cyc_data), .cyc_stat(cyc_stat), .store_qual(store_qual));

	task automatic stop_test;
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// the whole run needs well under a thousand cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures = failures + 1;
			stop_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp, input string what);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(what, exp, rdata);
	endtask

	// qualifier on the full address, data and status left open
	task automatic setq(input int q, input logic [31:0] a);
		wr_reg(10'h040 + 10'(q) * 10'h010, a);
		wr_reg(10'h044 + 10'(q) * 10'h010, 32'h00FFFFFF);
	endtask

	// exp holds rec_valid, rec_adv_tag, rec_trig, trig_out
	task automatic cyc(input logic [23:0] a, input logic sq, input int gap, input logic [3:0] exp);
		u_far.send(a, sq, gap);
		#1;
		chk("record", {28'h0, exp}, {28'h0, rec_valid, rec_adv_tag, rec_trig, trig_out});
		if (exp[3]) begin
			chk("rec_addr", {8'h00, a}, {8'h00, rec_addr});
			chk("rec_data", {16'h0000, ~a[15:0]}, {16'h0000, rec_data});
			chk("rec_stat", {24'h00_0000, a[7:0]}, {24'h00_0000, rec_stat});
		end
	endtask

	task automatic start(input logic [31:0] c);
		wr_reg(tts_pkg::OFS_CTRL, 32'h0);
		wr_reg(tts_pkg::OFS_CTRL, c);
		repeat (2) @(posedge mclk);
	endtask

	task automatic irq_chk(input logic exp);
		repeat (2) @(posedge mclk);
		#1;
		chk("irq", {31'h0, exp}, {31'h0, irq});
	endtask

	initial begin
		rst = 1'b1;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		failures = 0;
		checked = 0;
		cycles = 0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		rd_chk(tts_pkg::OFS_CTRL, 32'h0, "ctrl_reset");
		rd_chk(tts_pkg::OFS_STATUS, 32'h0, "status_reset");
		rd_chk(tts_pkg::OFS_IRQ_MASK, 32'h0, "mask_reset");
		rd_chk(10'h3F0, 32'h0, "unmapped");
		chk("rec_reset", 32'h0, {28'h0, rec_valid, rec_adv_tag, rec_trig, trig_out});
		for (int i = 0; i < 7; i++)
			setq(i, 32'h100 + i);
		setq(7, 32'h300);
		setq(8, 32'h200);
		setq(9, 32'h201);
		// seven terms, last index 7 written to see it clipped
		start(32'h71);
		for (int i = 0; i < 7; i++)
			cyc(24'(32'h100 + i), 1'b0, 0, (i == 6) ? 4'hF : 4'hC);
		// counted middle term
		wr_reg(10'h104, 32'h3);
		start(32'h21);
		cyc(24'h101, 1'b0, 0, 4'h0);
		cyc(24'h100, 1'b0, 2, 4'hC);
		cyc(24'h101, 1'b0, 0, 4'h0);
		cyc(24'h101, 1'b1, 0, 4'h8);
		cyc(24'h101, 1'b0, 0, 4'hC);
		rd_chk(tts_pkg::OFS_STATUS, 32'h42, "status_term");
		cyc(24'h102, 1'b0, 0, 4'hF);
		cyc(24'h555, 1'b1, 0, 4'h9);
		rd_chk(tts_pkg::OFS_IRQ_STAT, 32'h3, "irq_stat");
		irq_chk(1'b0);
		wr_reg(tts_pkg::OFS_IRQ_MASK, 32'h1);
		irq_chk(1'b1);
		wr_reg(tts_pkg::OFS_IRQ_STAT, 32'h1);
		irq_chk(1'b0);
		rd_chk(tts_pkg::OFS_IRQ_STAT, 32'h2, "irq_w1c");
		// global restart
		start(32'h25);
		cyc(24'h100, 1'b0, 0, 4'hC);
		rd_chk(tts_pkg::OFS_STATUS, 32'h41, "status_adv");
		cyc(24'h300, 1'b0, 0, 4'hC);
		rd_chk(tts_pkg::OFS_STATUS, 32'h40, "status_restart");
		cyc(24'h101, 1'b0, 0, 4'h0);
		cyc(24'h100, 1'b0, 0, 4'hC);
		for (int i = 0; i < 3; i++)
			cyc(24'h101, 1'b0, 0, (i == 2) ? 4'hC : 4'h0);
		cyc(24'h300, 1'b0, 0, 4'hC);
		cyc(24'h102, 1'b0, 0, 4'h0);
		// window mode, last index 6 falls back to four terms
		start(32'h6F);
		cyc(24'h100, 1'b1, 0, 4'hC);
		cyc(24'h101, 1'b0, 0, 4'hC);
		cyc(24'h102, 1'b0, 0, 4'hC);
		cyc(24'h103, 1'b1, 0, 4'h0);
		cyc(24'h200, 1'b0, 0, 4'hC);
		rd_chk(tts_pkg::OFS_STATUS, 32'h63, "status_window");
		cyc(24'h300, 1'b0, 0, 4'h8);
		cyc(24'h201, 1'b0, 0, 4'hC);
		cyc(24'h555, 1'b1, 0, 4'h0);
		cyc(24'h200, 1'b0, 0, 4'hC);
		cyc(24'h103, 1'b0, 0, 4'hF);
		rd_chk(tts_pkg::OFS_IRQ_STAT, 32'hF, "irq_all");
		irq_chk(1'b1);
		// single trigger term qualified on status and data as well as address
		wr_reg(10'h04C, 32'h00FFFFFF);
		wr_reg(10'h048, 32'h0001FEFF);
		start(32'h01);
		cyc(24'h100, 1'b0, 0, 4'h0);
		wr_reg(10'h048, 32'h0000FEFF);
		cyc(24'h100, 1'b0, 0, 4'hF);
		stop_test();
	end
endmodule // test_trace_trigger_sequencer
